// *** design/timer_regs.svh ***
// register offsets, field positions, reset values and counts of the timer
// ****************************************************************
// How it works
// - counter readable as high and low bytes
// - byte read latches both; release after other
// - reset, counter write, main write re-arm latch
// - reset clears the counter
// - debug halt freezes counter and latch state
// - at modulo: wrap or reverse, set overflow
// - modulo byte write blocks overflow until pair
// - modulo resets to zero, meaning free running
// - capture mode: active pin edge sets flag
// - compare or edge pwm: match sets flag
// - center pwm: every match sets flag
// - interrupt request while flag and enable set
// - clear flag: read while set, write zero
// - new event between read and write keeps flag
// - reset clears flag; writing one does nothing
// - bit 6 is channel interrupt enable
// - bit 5 set selects edge-aligned pwm
// - bit 4 picks capture or compare
// - center select: up/down, all channels center pwm
// ****************************************************************
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// byte addresses on the register bus
`define OFS_MAIN 8'h00
`define OFS_CNT_HI 8'h04
`define OFS_CNT_LO 8'h08
`define OFS_MOD_HI 8'h0C
`define OFS_MOD_LO 8'h10
`define OFS_CH_BASE 8'h20
`define OFS_CH_VAL 8'h04
`define CH_IDX_LSB 3
`define NUM_CH 2

// main status/control fields
`define MAIN_OVF 7
`define MAIN_OVF_IE 6
`define MAIN_CENTER 5
`define MAIN_CLKS_LSB 3
`define MAIN_PS_LSB 0

// channel status/control fields
`define CH_FLAG 7
`define CH_IE 6
`define CH_MSB 5
`define CH_MSA 4
`define CH_ELS_LSB 2

// reset values
`define RST_CNT 16'h0000
`define RST_MOD 16'h0000
`define RST_MAIN 7'h00
`define RST_CH_SC 8'h00
`define RST_CH_VAL 16'h0000
`define CNT_FULL 16'hFFFF

`endif

// *** design/timer_pkg.sv ***
// types shared by the timer design
package timer_pkg;
  typedef enum logic [2:0] {SEL_NONE, SEL_MAIN, SEL_CNT_HI, SEL_CNT_LO, SEL_MOD_HI,
    SEL_MOD_LO, SEL_CH_SC, SEL_CH_VAL} reg_sel_e;
  typedef enum logic [1:0] {CLK_OFF, CLK_BUS, CLK_FIXED, CLK_EXT} clk_src_e;
endpackage

// *** design/timer_pwm_counter.sv ***
// 16-bit timer/pwm counter, modulo and channel status/control behind apb
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "timer_regs.svh"

module timer_pwm_counter (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic debug_halt, // background debug active
  input wire logic fixed_tick, // fixed system clock tick
  input wire logic ext_clk_in, // external clock input level
  input wire logic [`NUM_CH-1:0] ch_in, // channel pin levels
  output logic [`NUM_CH-1:0] ch_out, // channel pin drive value
  output logic [`NUM_CH-1:0] ch_oe, // channel pin drive enable
  output logic [`NUM_CH-1:0] ch_irq, // channel interrupt requests
  output logic ovf_irq // overflow interrupt request
);

  // ****************************************************************
  // address decode
  // ****************************************************************

  // map a byte address to the register it selects
  function automatic timer_pkg::reg_sel_e decode(input logic [7:0] a);
    timer_pkg::reg_sel_e s;
    s = timer_pkg::SEL_NONE;
    case (a)
      `OFS_MAIN: s = timer_pkg::SEL_MAIN;
      `OFS_CNT_HI: s = timer_pkg::SEL_CNT_HI;
      `OFS_CNT_LO: s = timer_pkg::SEL_CNT_LO;
      `OFS_MOD_HI: s = timer_pkg::SEL_MOD_HI;
      `OFS_MOD_LO: s = timer_pkg::SEL_MOD_LO;
      default:
      begin
        if (a >= `OFS_CH_BASE && a < 8'(`OFS_CH_BASE + 8 * `NUM_CH) && a[1:0] == 2'h0)
        begin
          if (a[2:0] == `OFS_CH_VAL)
            s = timer_pkg::SEL_CH_VAL;
          else if (a[2:0] == 3'h0)
            s = timer_pkg::SEL_CH_SC;
        end
      end
    endcase
    return s;
  endfunction

  timer_pkg::reg_sel_e sel;
  logic setup;
  logic wr_done;
  logic ch_idx;
  logic is_cnt;
  assign sel = decode(paddr);
  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;
  assign ch_idx = paddr[`CH_IDX_LSB];
  assign is_cnt = sel == timer_pkg::SEL_CNT_HI || sel == timer_pkg::SEL_CNT_LO;

  // ****************************************************************
  // state
  // ****************************************************************

  logic [15:0] cnt_r;
  logic dn_r;
  logic [15:0] mod_r;
  logic mod_wait_r;
  logic mod_wait_hi_r;
  logic [6:0] main_r;
  logic ovf_r;
  logic ovf_arm_r;
  logic lat_r;
  logic lat_hi_r;
  logic [15:0] lat_val_r;
  logic [6:0] pre_r;
  logic ext_d_r;
  logic tick_d_r;
  logic [7:0] ch_sc [`NUM_CH];
  logic [15:0] ch_val [`NUM_CH];

  logic center;
  logic [1:0] clks;
  logic [2:0] ps;
  logic src_tick;
  logic [6:0] pre_mask;
  logic tick;
  logic [15:0] top;
  logic ovf_evt;
  assign center = main_r[`MAIN_CENTER];
  assign clks = main_r[`MAIN_CLKS_LSB +: 2];
  assign ps = main_r[`MAIN_PS_LSB +: 3];
  assign top = (mod_r == `RST_MOD) ? `CNT_FULL : mod_r;

  // ****************************************************************
  // clock source and prescaler
  // ****************************************************************

  // pick the source tick; no source means no ticks
  always_comb
  begin
    case (timer_pkg::clk_src_e'(clks))
      timer_pkg::CLK_OFF: src_tick = 1'b0;
      timer_pkg::CLK_BUS: src_tick = 1'b1;
      timer_pkg::CLK_FIXED: src_tick = fixed_tick;
      timer_pkg::CLK_EXT: src_tick = ext_clk_in && !ext_d_r;
      default: src_tick = 1'b0;
    endcase
  end

  assign pre_mask = 7'((8'h01 << ps) - 8'h01);
  assign tick = src_tick && !debug_halt && ((pre_r & pre_mask) == pre_mask);

  // external input edge detect and prescale count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_d_r <= 1'b0;
      pre_r <= 7'h00;
      tick_d_r <= 1'b0;
    end
    else
    begin
      ext_d_r <= ext_clk_in;
      tick_d_r <= tick;
      if (src_tick && !debug_halt)
        pre_r <= pre_r + 7'h01;
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************

  assign ovf_evt = tick && cnt_r == top && (!center || !dn_r);

  // up count with wrap, or up/down in center mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= `RST_CNT;
      dn_r <= 1'b0;
    end
    else if (wr_done && is_cnt)
    begin
      cnt_r <= `RST_CNT;
      dn_r <= 1'b0;
    end
    else if (tick)
    begin
      if (!center)
      begin
        dn_r <= 1'b0;
        cnt_r <= (cnt_r == top) ? `RST_CNT : cnt_r + 16'h0001;
      end
      else if (!dn_r)
      begin
        if (cnt_r == top)
        begin
          dn_r <= 1'b1;
          cnt_r <= cnt_r - 16'h0001;
        end
        else
          cnt_r <= cnt_r + 16'h0001;
      end
      else if (cnt_r == `RST_CNT)
      begin
        dn_r <= 1'b0;
        cnt_r <= cnt_r + 16'h0001;
      end
      else
        cnt_r <= cnt_r - 16'h0001;
    end
  end

  // read coherency latch for the two counter bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lat_r <= 1'b0;
      lat_hi_r <= 1'b0;
      lat_val_r <= `RST_CNT;
    end
    else if (wr_done && (is_cnt || sel == timer_pkg::SEL_MAIN))
      lat_r <= 1'b0;
    else if (setup && !pwrite && is_cnt && !debug_halt)
    begin
      if (!lat_r)
      begin
        lat_r <= 1'b1;
        lat_hi_r <= sel == timer_pkg::SEL_CNT_HI;
        lat_val_r <= cnt_r;
      end
      else if (lat_hi_r != (sel == timer_pkg::SEL_CNT_HI))
        lat_r <= 1'b0;
    end
  end

  // ****************************************************************
  // main control, modulo and overflow flag
  // ****************************************************************

  // main control bits and modulo bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_r <= `RST_MAIN;
      mod_r <= `RST_MOD;
      mod_wait_r <= 1'b0;
      mod_wait_hi_r <= 1'b0;
    end
    else if (wr_done)
    begin
      case (sel)
        timer_pkg::SEL_MAIN: main_r <= pwdata[6:0];
        timer_pkg::SEL_MOD_HI:
        begin
          mod_r[15:8] <= pwdata[7:0];
          mod_wait_r <= !(mod_wait_r && !mod_wait_hi_r);
          mod_wait_hi_r <= 1'b1;
        end
        timer_pkg::SEL_MOD_LO:
        begin
          mod_r[7:0] <= pwdata[7:0];
          mod_wait_r <= !(mod_wait_r && mod_wait_hi_r);
          mod_wait_hi_r <= 1'b0;
        end
        default: mod_wait_r <= mod_wait_r;
      endcase
    end
  end

  // overflow flag with read-then-write-zero clear; a new overflow wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovf_r <= 1'b0;
      ovf_arm_r <= 1'b0;
    end
    else if (ovf_evt && !mod_wait_r)
    begin
      ovf_r <= 1'b1;
      ovf_arm_r <= 1'b0;
    end
    else if (wr_done && sel == timer_pkg::SEL_MAIN)
    begin
      if (ovf_arm_r && !pwdata[`MAIN_OVF])
        ovf_r <= 1'b0;
      ovf_arm_r <= 1'b0;
    end
    else if (setup && !pwrite && sel == timer_pkg::SEL_MAIN && ovf_r)
      ovf_arm_r <= 1'b1;
  end

  // ****************************************************************
  // channels
  // ****************************************************************

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1)
    begin : chan
      logic [7:0] sc_r;
      logic [15:0] val_r;
      logic arm_r;
      logic in_d_r;
      logic out_r;
      logic oe_r;
      logic irq_r;
      logic [1:0] els;
      logic cap_mode;
      logic cmp_mode;
      logic pwm_mode;
      logic cap_evt;
      logic match_evt;
      logic evt;
      logic hit;
      assign els = sc_r[`CH_ELS_LSB +: 2];
      assign cap_mode = !center && !sc_r[`CH_MSB] && !sc_r[`CH_MSA];
      assign pwm_mode = center || sc_r[`CH_MSB];
      assign cmp_mode = !pwm_mode && sc_r[`CH_MSA];
      assign cap_evt = cap_mode && ((els[0] && ch_in[g] && !in_d_r)
        || (els[1] && !ch_in[g] && in_d_r));
      assign match_evt = !cap_mode && tick_d_r && cnt_r == val_r;
      assign evt = cap_evt || match_evt;
      assign hit = (sc_r[`CH_FLAG] || evt) && ch_idx == 1'(g);
      assign ch_sc[g] = sc_r;
      assign ch_val[g] = val_r;
      assign ch_out[g] = out_r;
      assign ch_oe[g] = oe_r;
      assign ch_irq[g] = irq_r;

      // flag, enable and mode bits of the channel
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sc_r <= `RST_CH_SC;
          arm_r <= 1'b0;
        end
        else
        begin
          if (wr_done && sel == timer_pkg::SEL_CH_SC && ch_idx == 1'(g))
            sc_r[6:2] <= pwdata[6:2];
          if (evt)
          begin
            sc_r[`CH_FLAG] <= 1'b1;
            arm_r <= 1'b0;
          end
          else if (wr_done && sel == timer_pkg::SEL_CH_SC && ch_idx == 1'(g))
          begin
            if (arm_r && !pwdata[`CH_FLAG])
              sc_r[`CH_FLAG] <= 1'b0;
            arm_r <= 1'b0;
          end
          else if (setup && !pwrite && sel == timer_pkg::SEL_CH_SC && hit)
            arm_r <= sc_r[`CH_FLAG];
        end
      end

      // channel value: software write or captured count
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          val_r <= `RST_CH_VAL;
        else if (cap_evt)
          val_r <= cnt_r;
        else if (wr_done && sel == timer_pkg::SEL_CH_VAL && ch_idx == 1'(g))
          val_r <= pwdata[15:0];
      end

      // pin drive and interrupt request
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          in_d_r <= 1'b0;
          out_r <= 1'b0;
          oe_r <= 1'b0;
          irq_r <= 1'b0;
        end
        else
        begin
          in_d_r <= ch_in[g];
          oe_r <= !cap_mode && els != 2'b00;
          irq_r <= sc_r[`CH_FLAG] && sc_r[`CH_IE];
          if (pwm_mode)
            out_r <= (cnt_r < val_r) ^ els[0];
          else if (cmp_mode && match_evt)
          begin
            case (els)
              2'b01: out_r <= !out_r;
              2'b10: out_r <= 1'b0;
              2'b11: out_r <= 1'b1;
              default: out_r <= out_r;
            endcase
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // register bus
  // ****************************************************************

  logic [15:0] cnt_view;
  logic [7:0] rd_byte;
  logic [31:0] rd_val;
  assign cnt_view = lat_r ? lat_val_r : cnt_r;

  // read data for the addressed register
  always_comb
  begin
    rd_byte = 8'h00;
    rd_val = 32'h0000_0000;
    case (sel)
      timer_pkg::SEL_MAIN: rd_byte = {ovf_r, main_r};
      timer_pkg::SEL_CNT_HI: rd_byte = cnt_view[15:8];
      timer_pkg::SEL_CNT_LO: rd_byte = cnt_view[7:0];
      timer_pkg::SEL_MOD_HI: rd_byte = mod_r[15:8];
      timer_pkg::SEL_MOD_LO: rd_byte = mod_r[7:0];
      timer_pkg::SEL_CH_SC: rd_byte = ch_sc[ch_idx];
      default: rd_byte = 8'h00;
    endcase
    if (sel == timer_pkg::SEL_CH_VAL)
      rd_val = {16'h0000, ch_val[ch_idx]};
    else
      rd_val = {24'h00_0000, rd_byte};
  end

  // one wait-free access phase; data sampled at setup
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && sel == timer_pkg::SEL_NONE;
      if (setup && !pwrite)
        prdata <= rd_val;
    end
  end

  // overflow interrupt request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ovf_irq <= 1'b0;
    else
      ovf_irq <= ovf_r && main_r[`MAIN_OVF_IE];
  end

endmodule

// *** tb/timer_pwm_counter_monitor.sv ***
// concurrent checks on the timer's ports
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_pwm_counter_monitor (
  input wire logic clk, // bus clock
  input wire logic rst_n, // reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic debug_halt, // debug halt
  input wire logic fixed_tick, // fixed tick
  input wire logic ext_clk_in, // external clock
  input wire logic [`NUM_CH-1:0] ch_in, // pin levels
  input wire logic [`NUM_CH-1:0] ch_out, // pin drive
  input wire logic [`NUM_CH-1:0] ch_oe, // pin enable
  input wire logic [`NUM_CH-1:0] ch_irq, // channel requests
  input wire logic ovf_irq // overflow request
);
  logic [1:0] pend_r; // modulo byte awaiting partner
  logic mwr; // completed write
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_s(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence halted_s;
    (debug_halt && !psel) [*4];
  endsequence
  assign mwr = psel && penable && pready && pwrite;
  // tracks a half-written modulo pair
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_r <= 2'h0;
    else if (mwr && paddr == 8'h0C)
      pend_r <= pend_r[1] ? 2'h0 : 2'h1;
    else if (mwr && paddr == 8'h10)
      pend_r <= pend_r[0] ? 2'h0 : 2'h2;
  end
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup_s ##0 paddr == 8'h14 |=> pslverr)
    else $error("unmapped access not refused");
  a_reset_quiet: assert property ($rose(rst_n) |-> !ovf_irq && ch_irq == '0)
    else $error("request active after reset");
  a_flag_write_one: assert property (wr_s(8'h20) ##0 pwdata[7:6] == 2'h3 && ch_irq[0]
    |=> ch_irq[0] [*2])
    else $error("writing one disturbed flag");
  a_ie_off_drop: assert property (wr_s(8'h20) ##0 !pwdata[6] |=> ##1 !ch_irq[0])
    else $error("request kept with enable off");
  a_halt_holds_out: assert property (halted_s |-> $stable(ch_out))
    else $error("pin moved during halt");
  a_ovf_clear_bus: assert property ($fell(ovf_irq) |-> $past(psel, 2) && $past(pwrite, 2))
    else $error("overflow request dropped without write");
  a_ch_clear_bus: assert property (|($past(ch_irq) & ~ch_irq) |-> $past(psel, 2) && $past(pwrite, 2))
    else $error("channel request dropped without write");
  a_pair_blocks_ovf: assert property (pend_r != 2'h0 && !ovf_irq && !psel && !$past(psel)
    |=> !ovf_irq)
    else $error("overflow during half modulo write");
endmodule

bind timer_pwm_counter timer_pwm_counter_monitor mon (.clk, .rst_n, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .debug_halt, .fixed_tick, .ext_clk_in, .ch_in,
  .ch_out, .ch_oe, .ch_irq, .ovf_irq);

// *** tb/tb_timer_pwm_counter.sv ***
// self-checking bench for the timer counter, modulo and channel registers
`timescale 1ns/1ps
`include "timer_regs.svh"
module tb_timer_pwm_counter;
  typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e; logic err;} row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, debug_halt, last_err, ovf_irq;
  logic fixed_tick, ext_clk_in;
  logic [7:0] paddr, h;
  logic [31:0] pwdata, prdata, r;
  logic [`NUM_CH-1:0] ch_in, ch_out, ch_oe, ch_irq;
  logic [2:0] irqs;
  int miscompares, tests_run, hi_n;
  row_s rows[11] = '{
    '{8'h0C, 0, 8'h00, 8'h00, 0},
    '{8'h10, 0, 8'h00, 8'h00, 0},
    '{8'h04, 0, 8'h00, 8'h00, 0},
    '{8'h08, 0, 8'h00, 8'h00, 0},
    '{8'h20, 0, 8'h00, 8'h00, 0},
    '{8'h0C, 1, 8'h12, 8'h00, 0},
    '{8'h0C, 0, 8'h00, 8'h12, 0},
    '{8'h04, 1, 8'h55, 8'h00, 0},
    '{8'h04, 0, 8'h00, 8'h00, 0},
    '{8'h14, 0, 8'h00, 8'h00, 1},
    '{8'h0C, 1, 8'h00, 8'h00, 0}};
  assign irqs = {ch_irq, ovf_irq};
  timer_pwm_counter dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .debug_halt, .fixed_tick, .ext_clk_in, .ch_in, .ch_out,
    .ch_oe, .ch_irq, .ovf_irq);
  // bus clock
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // one apb transfer, held until pready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk("pready", 1, pready);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wsig(input int k, input int lim, input string s);
    int n;
    n = 0;
    while (irqs[k] !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk(s, 1, irqs[k]);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    rst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    debug_halt = 0;
    fixed_tick = 0;
    ext_clk_in = 0;
    ch_in = 2'h3;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      xfer(rows[i].a, rows[i].w, rows[i].d, r);
      if (!rows[i].w)
      begin
        chk("row data", {24'h000000, rows[i].e}, r);
        chk("row err", {31'h0, rows[i].err}, {31'h0, last_err});
      end
    end
    done("table");
    xfer(8'h00, 1, 8'h08, r);
    xfer(8'h08, 0, 8'h00, r);
    wt(300);
    xfer(8'h04, 0, 8'h00, r);
    chk("hi held", 0, r);
    xfer(8'h04, 0, 8'h00, r);
    h = r[7:0];
    chk("hi live", 1, h != 8'h00);
    wt(300);
    xfer(8'h00, 1, 8'h08, r);
    xfer(8'h04, 0, 8'h00, r);
    chk("hi after main write", 1, r[7:0] != h);
    wt(300);
    xfer(8'h08, 1, 8'h00, r);
    xfer(8'h04, 0, 8'h00, r);
    chk("hi after count write", 0, r);
    xfer(8'h08, 0, 8'h00, r);
    xfer(8'h04, 0, 8'h00, r);
    h = r[7:0];
    debug_halt <= 1'b1;
    xfer(8'h08, 0, 8'h00, r);
    debug_halt <= 1'b0;
    wt(300);
    xfer(8'h04, 0, 8'h00, r);
    chk("latch kept in halt", {24'h000000, h}, r);
    xfer(8'h08, 0, 8'h00, r);
    done("counter");
    xfer(8'h08, 1, 8'h00, r);
    xfer(8'h0C, 1, 8'h00, r);
    xfer(8'h10, 1, 8'h10, r);
    xfer(8'h00, 1, 8'h48, r);
    wsig(0, 40, "ovf set");
    xfer(8'h08, 0, 8'h00, r);
    chk("count within modulo", 1, r <= 32'h10);
    xfer(8'h04, 0, 8'h00, r);
    xfer(8'h00, 1, 8'h40, r);
    xfer(8'h00, 0, 8'h00, r);
    xfer(8'h00, 1, 8'h40, r);
    wt(1);
    chk("ovf cleared", 0, ovf_irq);
    xfer(8'h0C, 1, 8'h00, r);
    xfer(8'h00, 1, 8'h48, r);
    wt(60);
    chk("ovf held off", 0, ovf_irq);
    xfer(8'h10, 1, 8'h10, r);
    wsig(0, 40, "ovf after pair");
    done("overflow");
    xfer(8'h24, 1, 8'h08, r);
    xfer(8'h20, 1, 8'h54, r);
    wt(2);
    chk("compare drives pin", 1, ch_oe[0]);
    wsig(1, 40, "compare flag");
    xfer(8'h20, 1, 8'hD4, r);
    wt(2);
    chk("flag write one", 1, ch_irq[0]);
    xfer(8'h20, 1, 8'h14, r);
    wt(2);
    chk("irq disabled", 0, ch_irq[0]);
    xfer(8'h2C, 1, 8'h04, r);
    xfer(8'h28, 1, 8'h28, r);
    debug_halt <= 1'b1;
    wt(20);
    debug_halt <= 1'b0;
    wt(2);
    chk("pwm drives pin", 1, ch_oe[1]);
    hi_n = 0;
    repeat (34)
    begin
      @(posedge clk);
      hi_n += ch_out[1];
    end
    chk("pwm high count", 8, hi_n);
    xfer(8'h28, 1, 8'h04, r);
    xfer(8'h28, 0, 8'h00, r);
    xfer(8'h28, 1, 8'h44, r);
    wt(2);
    chk("capture frees pin", 0, ch_oe[1]);
    chk("flag cleared", 0, ch_irq[1]);
    ch_in <= 2'h1;
    wt(5);
    chk("falling ignored", 0, ch_irq[1]);
    ch_in <= 2'h3;
    wsig(2, 5, "rising sets flag");
    xfer(8'h28, 0, 8'h00, r);
    ch_in <= 2'h1;
    wt(2);
    ch_in <= 2'h3;
    wt(2);
    xfer(8'h28, 1, 8'h44, r);
    wt(1);
    chk("new event kept", 1, ch_irq[1]);
    xfer(8'h28, 0, 8'h00, r);
    chk("status read", 32'hC4, r);
    xfer(8'h28, 1, 8'h44, r);
    wt(1);
    chk("flag cleared by pair", 0, ch_irq[1]);
    done("channels");
    // fixed tick source: counter steps once per high tick sample
    xfer(8'h00, 1, 8'h10, r);
    xfer(8'h08, 1, 8'h00, r);
    fixed_tick <= 1'b1;
    wt(7);
    fixed_tick <= 1'b0;
    xfer(8'h08, 0, 8'h00, r);
    chk("fixed tick count", 7, r);
    xfer(8'h04, 0, 8'h00, r);
    // external clock source with the shared channel pin released
    xfer(8'h20, 1, 8'h00, r);
    xfer(8'h00, 1, 8'h18, r);
    xfer(8'h08, 1, 8'h00, r);
    repeat (5)
    begin
      ext_clk_in <= 1'b1;
      wt(2);
      ext_clk_in <= 1'b0;
      wt(2);
    end
    xfer(8'h08, 0, 8'h00, r);
    chk("ext clock count", 5, r);
    chk("ext pin free", 0, ch_oe[0]);
    xfer(8'h04, 0, 8'h00, r);
    done("clock sources");
    wrap_up();
  end
endmodule
